// File: inc/txlp_pkg.sv
/*
  Constants for the transmit line processor: register map, field layout,
  interrupt bits, command word and framing encodings.
  Assumes a 32-bit APB register bus and synchronous neighbouring logic.
*/
package txlp_pkg;

  // ----------------------------------------------------------------------
  // Channel space
  // ----------------------------------------------------------------------
  localparam int             CHAN_NUM  = 2047;
  localparam int             CHAN_W    = 11;
  localparam logic [10:0]    CHAN_LAST = 11'h7fe;
  localparam int             ADDR_W    = 16;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [15:0]    OFS_SETUP_BASE = 16'h0000;
  localparam logic [15:0]    OFS_STATE_BASE = 16'h2000;
  localparam logic [15:0]    OFS_IRQ_STAT   = 16'h4000;
  localparam logic [15:0]    OFS_IRQ_MASK   = 16'h4004;
  localparam logic [15:0]    OFS_CMD        = 16'h4008;

  // ----------------------------------------------------------------------
  // Channel setup and state fields
  // ----------------------------------------------------------------------
  localparam int             FLD_FRAME_HI  = 31;
  localparam int             FLD_FRAME_LO  = 30;
  localparam int             FLD_INV       = 29;
  localparam int             FLD_MASK_HI   = 28;
  localparam int             FLD_MASK_LO   = 21;
  localparam int             FLD_PADJ      = 2;
  localparam int             FLD_UNDR_IEN  = 1;
  localparam int             FLD_EOM_IEN   = 0;
  localparam int             FLD_ACTIVE    = 0;
  localparam logic [31:0]    SETUP_RW_MASK = 32'hffe0_0007;

  // ----------------------------------------------------------------------
  // Interrupt status and command word
  // ----------------------------------------------------------------------
  localparam int             IRQ_W        = 2;
  localparam int             IRQ_EOM      = 0;
  localparam int             IRQ_UNDR     = 1;
  localparam logic [1:0]     IRQ_RESET    = 2'h0;
  localparam int             CMD_CHAN_LO  = 0;
  localparam int             CMD_ACT      = 12;
  localparam int             CMD_DEACT    = 13;
  localparam int             CMD_SOFT_RST = 31;

  // ----------------------------------------------------------------------
  // Framing and line constants
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FRM_TRANSP     = 2'b00,
    FRM_HDLC_NOFCS = 2'b01,
    FRM_HDLC_FCS16 = 2'b10,
    FRM_HDLC_FCS32 = 2'b11
  } txlp_framing_e;

  localparam logic [2:0]     FCS_NONE_BYTES = 3'h0;
  localparam logic [2:0]     FCS16_BYTES    = 3'h2;
  localparam logic [2:0]     FCS32_BYTES    = 3'h4;
  localparam int             ZINS_W         = 16;
  localparam int             IDLE_DIV_SH    = 3;
  localparam int             IDLE_W         = ZINS_W - IDLE_DIV_SH;
  localparam logic           PAD_FILL       = 1'b1;
  localparam logic [7:0]     SLOT_IDLE      = 8'hff;

endpackage : txlp_pkg

// File: hdl/txlp_bitpack.sv
/*
  Places the data bits of one time slot into the positions enabled by the
  sub-channel mask and applies optional inversion to those data bits.
  Assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ps
module txlp_bitpack
  import txlp_pkg::*;
(
  // Slot data and setup
  input  wire logic [7:0] data,
  input  wire logic [7:0] mask,
  input  wire logic       inv,
  // Packed slot
  output logic [7:0]      slot
);

  // ----------------------------------------------------------------------
  // Rank of each bit among the enabled positions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] ones_below(input logic [7:0] m, input int n);
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        cnt = cnt + {2'b00, m[i]};
      end
    end
    return cnt;
  endfunction : ones_below

  // ----------------------------------------------------------------------
  // Per-bit placement
  // ----------------------------------------------------------------------
  for (genvar j = 0; j < 8; j++) begin : g_bit
    wire logic [2:0] rank = ones_below(mask, j);
    // The k-th enabled position carries data bit k; others are padding.
    assign slot[j] = mask[j] ? (data[rank] ^ inv) : PAD_FILL;
  end

endmodule : txlp_bitpack

// File: hdl/txlp_top.sv
/*
  Transmit line processor channel control: per-channel setup and state
  registers on APB, channel activation, slot packing toward the serial
  interface unit, idle pad adjustment and interrupt reporting.
  Assumes framer, error sources and serial interface unit run on mclk.
*/
`timescale 1ns/1ps
module txlp_top
  import txlp_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Slot request from the serial interface unit
  input  wire logic              slot_req,
  input  wire logic [CHAN_W-1:0] slot_chan,
  input  wire logic [7:0]        slot_data,
  // Packed slot toward the serial interface unit
  output logic                   slot_valid,
  output logic [7:0]             slot_byte,
  output logic [1:0]             slot_framing,
  output logic [2:0]             slot_fcs_len,
  // Message events from the framer
  input  wire logic [CHAN_W-1:0] frm_chan,
  input  wire logic              frm_zins,
  input  wire logic              frm_msg_end,
  input  wire logic              frm_underrun,
  // Channel errors
  input  wire logic [CHAN_W-1:0] err_chan,
  input  wire logic              tx_buffer_error,
  input  wire logic              tx_frame_align_change_error,
  // Idle shortening result
  output logic                   idle_cut_valid,
  output logic [IDLE_W-1:0]      idle_cut,
  // Interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [31:0]       setup_mem [0:CHAN_NUM-1];
  logic [CHAN_NUM-1:0] active;
  logic [CHAN_NUM-1:0] next_active;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [ZINS_W-1:0] zins_cnt;
  logic [7:0]        slot_mask_q;
  logic [7:0]        slot_data_q;
  logic              slot_inv_q;
  logic              slot_live_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire logic [CHAN_W-1:0] acc_idx  = paddr[12:2];
  wire logic              idx_ok   = (acc_idx <= CHAN_LAST) && (paddr[1:0] == 2'b00);
  wire logic              hit_set  = (paddr[15:13] == OFS_SETUP_BASE[15:13]) && idx_ok;
  wire logic              hit_st   = (paddr[15:13] == OFS_STATE_BASE[15:13]) && idx_ok;
  wire logic              hit_stat = (paddr == OFS_IRQ_STAT);
  wire logic              hit_mask = (paddr == OFS_IRQ_MASK);
  wire logic              hit_cmd  = (paddr == OFS_CMD);
  wire logic              addr_ok  = hit_set | hit_st | hit_stat | hit_mask | hit_cmd;
  wire logic              setup_ph = psel & ~penable;
  wire logic              acc_ph   = psel & penable;
  wire logic              wr_acc   = acc_ph & pwrite & addr_ok;
  wire logic              cmd_wr   = wr_acc & hit_cmd;

  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~addr_ok;

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  wire logic [31:0] rd_set   = setup_mem[acc_idx];
  wire logic [31:0] rd_st    = {31'h0, active[acc_idx]};
  wire logic [31:0] rd_mux   = hit_set  ? rd_set :
                               hit_st   ? rd_st :
                               hit_stat ? {30'h0, irq_stat} :
                               hit_mask ? {30'h0, irq_mask} : 32'h0;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Channel setup memory (no reset, contents undefined until written)
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wr_acc && hit_set) begin
      setup_mem[acc_idx] <= pwdata & SETUP_RW_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Channel activation state
  // ----------------------------------------------------------------------
  wire logic [CHAN_W-1:0] cmd_chan = pwdata[CMD_CHAN_LO +: CHAN_W];
  wire logic cmd_ok   = cmd_wr && (cmd_chan <= CHAN_LAST);
  wire logic soft_rst = cmd_wr && pwdata[CMD_SOFT_RST];
  wire logic act_cmd  = cmd_ok && pwdata[CMD_ACT] && !soft_rst;
  wire logic err_ok   = err_chan <= CHAN_LAST;
  wire logic err_any  = (tx_buffer_error | tx_frame_align_change_error) && err_ok;

  always_comb begin
    next_active = active;
    if (err_any) begin
      next_active[err_chan] = 1'b0;
    end
    if (cmd_ok && pwdata[CMD_DEACT]) begin
      next_active[cmd_chan] = 1'b0;
    end
    if (soft_rst) begin
      next_active = '0;
    end
    if (act_cmd) begin
      next_active[cmd_chan] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      active <= '0;
    end else begin
      active <= next_active;
    end
  end

  // ----------------------------------------------------------------------
  // Slot packing toward the serial interface unit
  // ----------------------------------------------------------------------
  wire logic [31:0] slot_cfg  = setup_mem[slot_chan];
  wire logic        slot_live = (slot_chan <= CHAN_LAST) && active[slot_chan];
  wire logic [7:0]  slot_mask = slot_live ? slot_cfg[FLD_MASK_HI:FLD_MASK_LO] : 8'h00;
  wire logic [1:0]  slot_frm  = slot_cfg[FLD_FRAME_HI:FLD_FRAME_LO];
  wire logic [7:0]  packed_byte;
  logic      [2:0]  fcs_len;

  txlp_bitpack u_pack (
    .data (slot_data),
    .mask (slot_mask),
    .inv  (slot_cfg[FLD_INV]),
    .slot (packed_byte)
  );

  always_comb begin
    case (txlp_framing_e'(slot_frm))
      FRM_HDLC_FCS16: fcs_len = FCS16_BYTES;
      FRM_HDLC_FCS32: fcs_len = FCS32_BYTES;
      default:        fcs_len = FCS_NONE_BYTES;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      slot_valid   <= 1'b0;
      slot_byte    <= SLOT_IDLE;
      slot_framing <= 2'b00;
      slot_fcs_len <= FCS_NONE_BYTES;
      slot_mask_q  <= 8'h00;
      slot_data_q  <= 8'h00;
      slot_inv_q   <= 1'b0;
      slot_live_q  <= 1'b0;
    end else begin
      slot_valid <= slot_req;
      if (slot_req) begin
        slot_byte    <= slot_live ? packed_byte : SLOT_IDLE;
        slot_framing <= slot_frm;
        slot_fcs_len <= fcs_len;
        slot_mask_q  <= slot_mask;
        slot_data_q  <= slot_data;
        slot_inv_q   <= slot_cfg[FLD_INV];
        slot_live_q  <= slot_live;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Zero insertion count and idle shortening
  // ----------------------------------------------------------------------
  wire logic [31:0]       frm_cfg    = setup_mem[frm_chan];
  wire logic [ZINS_W-1:0] zins_total = zins_cnt + {{(ZINS_W-1){1'b0}}, frm_zins};
  wire logic [IDLE_W-1:0] zins_div   = zins_total[ZINS_W-1:IDLE_DIV_SH];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      zins_cnt       <= '0;
      idle_cut       <= '0;
      idle_cut_valid <= 1'b0;
    end else begin
      idle_cut_valid <= frm_msg_end;
      if (frm_msg_end) begin
        zins_cnt <= '0;
        idle_cut <= frm_cfg[FLD_PADJ] ? zins_div : '0;
      end else begin
        zins_cnt <= zins_total;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------------
  wire logic [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_EOM]  = frm_msg_end && frm_cfg[FLD_EOM_IEN];
  assign irq_ev[IRQ_UNDR] = frm_underrun && frm_cfg[FLD_UNDR_IEN];
  wire logic [IRQ_W-1:0] irq_w1c = (wr_acc && hit_stat) ? pwdata[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~irq_w1c) | irq_ev;
      if (wr_acc && hit_mask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_STATE_RO: assert property (@(posedge mclk) disable iff (!nrst)
    (acc_ph && pwrite && hit_st && !err_any) |=> (active == $past(active)))
    else $error("state register write changed channel state");

  AST_ERR_CLEARS: assert property (@(posedge mclk) disable iff (!nrst)
    (err_any && !act_cmd) |=> !active[$past(err_chan)])
    else $error("channel error did not clear active flag");

  AST_SET_BY_CMD: assert property (@(posedge mclk) disable iff (!nrst)
    (|(active & ~$past(active))) |-> $past(act_cmd))
    else $error("active flag set without activation command");

  AST_FRAMING: assert property (@(posedge mclk) disable iff (!nrst)
    slot_req |=> (slot_framing == $past(slot_frm)) &&
                 (slot_fcs_len == (slot_framing == 2'b11 ? 3'h4 :
                                   slot_framing == 2'b10 ? 3'h2 : 3'h0)))
    else $error("framing or fcs length mismatch");

  AST_INVERT: assert property (@(posedge mclk) disable iff (!nrst)
    (slot_valid && slot_live_q && slot_mask_q == 8'hff) |->
      (slot_byte == (slot_data_q ^ {8{slot_inv_q}})))
    else $error("slot inversion wrong");

  AST_PAD_FILL: assert property (@(posedge mclk) disable iff (!nrst)
    slot_valid |-> ((slot_byte | slot_mask_q) == 8'hff))
    else $error("non-data slot position not padded");

  AST_ZINS_COUNT: assert property (@(posedge mclk) disable iff (!nrst)
    (frm_zins && !frm_msg_end) |=> (zins_cnt == $past(zins_cnt) + 16'h0001))
    else $error("zero insertion not counted");

  AST_IDLE_CUT: assert property (@(posedge mclk) disable iff (!nrst)
    (frm_msg_end && frm_cfg[FLD_PADJ]) |=> idle_cut_valid && (idle_cut == $past(zins_div)))
    else $error("idle cut not count divided by eight");

  AST_EOM_IRQ: assert property (@(posedge mclk) disable iff (!nrst)
    (frm_msg_end && frm_cfg[FLD_EOM_IEN]) |=> irq_stat[IRQ_EOM])
    else $error("end of message interrupt not raised");

  AST_UNDR_GATE: assert property (@(posedge mclk) disable iff (!nrst)
    (!irq_stat[IRQ_UNDR] && !(frm_underrun && frm_cfg[FLD_UNDR_IEN])) |=> !irq_stat[IRQ_UNDR])
    else $error("underrun status set while not enabled");

  AST_RESET_IDLE: assert property (@(posedge mclk)
    !nrst |=> (active == '0))
    else $error("channel active after reset");

  AST_DEACT_CMD: assert property (@(posedge mclk) disable iff (!nrst)
    (cmd_ok && pwdata[CMD_DEACT] && !act_cmd) |=> !active[$past(cmd_chan)])
    else $error("deactivation command did not clear active flag");

  AST_SOFT_RST_ALL: assert property (@(posedge mclk) disable iff (!nrst)
    soft_rst |=> (active == '0))
    else $error("soft reset left a channel active");

  AST_ACT_CMD: assert property (@(posedge mclk) disable iff (!nrst)
    act_cmd |=> active[$past(cmd_chan)])
    else $error("activation command did not set active flag");

  AST_STATE_READ: assert property (@(posedge mclk) disable iff (!nrst)
    (setup_ph && !pwrite && hit_st) |=>
      ((prdata[31:1] == 31'h0) && (prdata[0] == $past(active[acc_idx]))))
    else $error("state register read data wrong");

  AST_INACTIVE_IDLE: assert property (@(posedge mclk) disable iff (!nrst)
    (slot_req && !slot_live) |=> (slot_byte == SLOT_IDLE))
    else $error("inactive channel slot not idle");

  AST_DATA_PLACE: assert property (@(posedge mclk) disable iff (!nrst)
    (slot_valid && slot_live_q && slot_mask_q == 8'h01) |->
      (slot_byte == {7'h7f, slot_data_q[0] ^ slot_inv_q}))
    else $error("single position slot data misplaced");

  AST_ZINS_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
    frm_msg_end |=> (zins_cnt == '0))
    else $error("zero insertion count not cleared at message end");

  AST_IDLE_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    (frm_msg_end && !frm_cfg[FLD_PADJ]) |=> idle_cut_valid && (idle_cut == '0))
    else $error("idle cut reported with pad adjustment off");

  AST_EOM_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
    (!irq_stat[IRQ_EOM] && !(frm_msg_end && frm_cfg[FLD_EOM_IEN])) |=> !irq_stat[IRQ_EOM])
    else $error("end of message status set while not enabled");

  AST_UNDR_IRQ: assert property (@(posedge mclk) disable iff (!nrst)
    (frm_underrun && frm_cfg[FLD_UNDR_IEN]) |=> irq_stat[IRQ_UNDR])
    else $error("enabled underrun not recorded");

endmodule : txlp_top

// File: test/txlp_siu_model.sv
/*
  Serial interface unit model: asks for slot bytes and collects answers.
  Assumes the block answers on the same mclk edge that takes a request.
*/
`timescale 1ns/1ps
module txlp_serial_model
  import txlp_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Slot request
  output logic                   slot_req,
  output logic [CHAN_W-1:0]      slot_chan,
  output logic [7:0]             slot_data,
  // Slot answer
  input  wire logic              slot_valid,
  input  wire logic [7:0]        slot_byte,
  input  wire logic [1:0]        slot_framing,
  input  wire logic [2:0]        slot_fcs_len
);
  initial begin
    slot_req  = 1'b0;
    slot_chan = '0;
    slot_data = 8'h00;
  end

  // Data left behind a request is inverted so a stale byte never matches.
  task automatic fetch(input logic [CHAN_W-1:0] ch, input logic [7:0] d,
                       output logic [7:0] b, output logic [1:0] f,
                       output logic [2:0] n, output logic v);
    @(posedge mclk);
    slot_req  <= 1'b1;
    slot_chan <= ch;
    slot_data <= d;
    @(posedge mclk);
    slot_req  <= 1'b0;
    slot_data <= ~d;
    #1;
    v = slot_valid;
    b = slot_byte;
    f = slot_framing;
    n = slot_fcs_len;
  endtask : fetch
endmodule : txlp_serial_model

// File: test/tb.sv
/*
  Self-checking bench for the transmit line processor.
  Assumes the serial side model file and the package are compiled first.
*/
`timescale 1ns/1ps
module tb
  import txlp_pkg::*;
;
  localparam logic [31:0] C_ACT = 32'h1 << CMD_ACT;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, last_err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic slot_req, slot_valid, frm_zins, frm_msg_end, frm_underrun;
  logic tx_buffer_error, tx_frame_align_change_error, idle_cut_valid, irq;
  logic [CHAN_W-1:0] slot_chan, frm_chan, err_chan;
  logic [7:0] slot_data, slot_byte;
  logic [1:0] slot_framing;
  logic [2:0] slot_fcs_len;
  logic [IDLE_W-1:0] idle_cut;
  int bad_count, checks_done, cyc;

  txlp_top dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .slot_req(slot_req), .slot_chan(slot_chan), .slot_data(slot_data),
    .slot_valid(slot_valid), .slot_byte(slot_byte), .slot_framing(slot_framing),
    .slot_fcs_len(slot_fcs_len), .frm_chan(frm_chan), .frm_zins(frm_zins),
    .frm_msg_end(frm_msg_end), .frm_underrun(frm_underrun), .err_chan(err_chan),
    .tx_buffer_error(tx_buffer_error),
    .tx_frame_align_change_error(tx_frame_align_change_error),
    .idle_cut_valid(idle_cut_valid), .idle_cut(idle_cut), .irq(irq));
  txlp_serial_model line_side (.mclk(mclk), .slot_req(slot_req), .slot_chan(slot_chan),
    .slot_data(slot_data), .slot_valid(slot_valid), .slot_byte(slot_byte),
    .slot_framing(slot_framing), .slot_fcs_len(slot_fcs_len));

  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask : wr

  task automatic rdw(input logic [15:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d);
  endtask : rdw

  function automatic logic [15:0] sa(input int ch);
    return OFS_SETUP_BASE + 16'(ch * 4);
  endfunction : sa

  function automatic logic [15:0] ta(input int ch);
    return OFS_STATE_BASE + 16'(ch * 4);
  endfunction : ta

  function automatic logic [7:0] pack(input logic [7:0] d, m, input logic inv);
    int k;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      pack[i] = m[i] ? d[k] ^ inv : 1'b1;
      if (m[i]) k++;
    end
  endfunction : pack

  task automatic errp(input logic [CHAN_W-1:0] ch, input logic buf_e);
    @(posedge mclk);
    err_chan <= ch;
    tx_buffer_error <= buf_e;
    tx_frame_align_change_error <= ~buf_e;
    @(posedge mclk);
    tx_buffer_error <= 1'b0;
    tx_frame_align_change_error <= 1'b0;
  endtask : errp

  // Zero insertions are held for nz edges plus the end-of-message edge.
  task automatic msg(input logic [CHAN_W-1:0] ch, input int nz, input logic undr);
    @(posedge mclk);
    frm_chan <= ch;
    frm_zins <= 1'b1;
    repeat (nz) @(posedge mclk);
    frm_msg_end <= 1'b1;
    frm_underrun <= undr;
    @(posedge mclk);
    frm_zins <= 1'b0;
    frm_msg_end <= 1'b0;
    frm_underrun <= 1'b0;
    #1;
  endtask : msg

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    chk("irq reset", 32'(irq), 32'h0);
    chk("pready idle", 32'(pready), 32'h1);
    rdw(ta(0), d);
    chk("state reset", d, 32'h0);
    wr(sa(5), 32'hffff_ffff);
    rdw(sa(5), d);
    chk("setup readback", d, SETUP_RW_MASK);
    rdw(ta(2046), d);
    chk("last state err", 32'(last_err), 32'h0);
    rdw(16'h3ffc, d);
    chk("unmapped err", 32'(last_err), 32'h1);
  endtask : t_regs

  task automatic t_active();
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      wr(sa(9), 32'h4020_0000);
      wr(OFS_CMD, C_ACT | 32'd9);
      rdw(ta(9), d);
      chk("activated", d, 32'h1);
      wr(ta(9), 32'h0);
      rdw(ta(9), d);
      chk("state write ignored", d, 32'h1);
      rdw(ta(10), d);
      chk("neighbour idle", d, 32'h0);
      case (k)
        0: wr(OFS_CMD, (32'h1 << CMD_DEACT) | 32'd9);
        1: errp(11'd9, 1'b1);
        2: errp(11'd9, 1'b0);
        default: wr(OFS_CMD, 32'h1 << CMD_SOFT_RST);
      endcase
      rdw(ta(9), d);
      chk("deactivated", d, 32'h0);
    end
  endtask : t_active

  task automatic t_slot();
    logic [7:0] m [4] = '{8'h81, 8'h5a, 8'hff, 8'h01};
    logic [7:0] b;
    logic [1:0] f;
    logic [2:0] n;
    logic v;
    for (int k = 0; k < 4; k++) begin
      wr(sa(k + 1), {k[1:0], k[0], m[k], 21'h0});
      wr(OFS_CMD, C_ACT | 32'(k + 1));
      line_side.fetch(11'(k + 1), 8'h36, b, f, n, v);
      chk("slot valid", 32'(v), 32'h1);
      chk("slot byte", 32'(b), 32'(pack(8'h36, m[k], k[0])));
      chk("framing", 32'(f), 32'(k));
      chk("fcs len", 32'(n), (k == 2) ? 32'h2 : (k == 3) ? 32'h4 : 32'h0);
    end
    wr(sa(100), 32'h4020_0000);
    line_side.fetch(11'd100, 8'h00, b, f, n, v);
    chk("inactive slot", 32'(b), 32'hff);
  endtask : t_slot

  task automatic t_idle();
    wr(sa(20), 32'h4020_0004);
    wr(OFS_CMD, C_ACT | 32'd20);
    msg(11'd20, 16, 1'b0);
    chk("idle valid", 32'(idle_cut_valid), 32'h1);
    chk("idle cut", 32'(idle_cut), 32'h2);
    wr(sa(20), 32'h4020_0000);
    msg(11'd20, 16, 1'b0);
    chk("idle cut off", 32'(idle_cut), 32'h0);
  endtask : t_idle

  task automatic t_irq();
    logic [31:0] d;
    wr(sa(30), 32'h4020_0001);
    msg(11'd30, 2, 1'b1);
    rdw(OFS_IRQ_STAT, d);
    chk("eom only", d, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h3);
    #1;
    chk("irq raised", 32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    #1;
    chk("irq cleared", 32'(irq), 32'h0);
    wr(sa(30), 32'h4020_0002);
    msg(11'd30, 0, 1'b1);
    rdw(OFS_IRQ_STAT, d);
    chk("underrun only", d, 32'h2);
    chk("irq underrun", 32'(irq), 32'h1);
  endtask : t_irq

  initial begin
    {mclk, nrst, psel, penable, pwrite, frm_zins, frm_msg_end, frm_underrun} = '0;
    {tx_buffer_error, tx_frame_align_change_error} = '0;
    {paddr, pwdata, frm_chan, err_chan} = '0;
    {bad_count, checks_done, cyc} = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_active();
    t_slot();
    t_idle();
    t_irq();
    conclude();
  end
endmodule : tb
